// ### common/utc_map.svh
`ifndef UTC_MAP_SVH
`define UTC_MAP_SVH

// mode codes
`define UTC_MODE_W          7
`define UTC_MODE_PIN_IN     7'h00
`define UTC_MODE_PIN_OUT    7'h01
`define UTC_MODE_CAPTURE    7'h02
`define UTC_MODE_COMPARE    7'h03
`define UTC_MODE_PULSE      7'h04

// bus select codes
`define UTC_BSL_BUS_A       2'h0
`define UTC_BSL_BUS_B       2'h1
`define UTC_BSL_INTERNAL    2'h3

// reset values
`define UTC_DATA_RESET      16'h0000

`endif

// ### common/utc_pkg.sv
package utc_pkg;

    // host access strobes for one cycle
    typedef struct packed {
        logic        wr_a;
        logic        wr_b;
        logic        wr_alt_a;
        logic        rd_a;
        logic        rd_b;
        logic [15:0] wdata;
    } utc_host_t;

    // channel control fields
    typedef struct packed {
        logic [6:0] mode;
        logic [1:0] bus_select_field;
        logic       edge_select_bit;
        logic       edge_polarity_bit;
        logic       force_match_a_bit;
    } utc_ctrl_t;

    // pulse width sequencing
    typedef enum logic [1:0] {
        UTC_PW_WAIT_LEAD  = 2'b00,
        UTC_PW_WAIT_TRAIL = 2'b01
    } utc_pw_state_t;

endpackage

// ### verification/unified_timer_channel_tb.sv
`timescale 1ns/10ps
`include "utc_map.svh"

module unified_timer_channel_tb;
    logic               clk;
    logic               rst;
    logic               fclr;
    logic               pin;
    logic               flag;
    logic               lvl;
    logic               pout;
    logic [15:0]        bus_a;
    logic [15:0]        bus_b;
    logic [15:0]        da;
    logic [15:0]        db;
    logic [15:0]        cnt;
    logic [15:0]        exp_a;
    logic [15:0]        exp_b;
    logic [15:0]        a1_v;
    logic [15:0]        m;
    logic [15:0]        c0;
    logic               s;
    logic               p;
    utc_pkg::utc_ctrl_t ctrl;
    utc_pkg::utc_host_t host;
    int                 errors;
    int                 checks_done;

    ////////////////////////////////////////////////////////////////////////////
    // clock and instances
    always #5 clk = ~clk;

    utc_channel dut (.CLK_IN(clk), .RST_IN(rst), .CTRL_IN(ctrl), .FLAG_CLEAR_IN(fclr), .HOST_IN(host),
                     .BUS_A_IN(bus_a), .BUS_B_IN(bus_b), .PIN_IN(pin), .DATA_A_OUT(da), .DATA_B_OUT(db),
                     .COUNT_OUT(cnt), .FLAG_OUT(flag), .PIN_LEVEL_OUT(lvl), .PIN_OUT(pout));

    utc_pin_model pin_drv (.clk_in(clk), .pin_out(pin));

    ////////////////////////////////////////////////////////////////////////////
    // helpers
    function automatic logic trig(input logic sel, input logic pol, input logic rise);
        return sel | (pol == rise);
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk1(input string nm, input logic e, input logic g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask

    // one-cycle host strobe, order wr_a wr_b wr_alt_a rd_a rd_b
    task automatic host_op(input logic [4:0] st, input logic [15:0] d);
        @(posedge clk);
        host <= utc_pkg::utc_host_t'({st, d});
        @(posedge clk);
        host <= '0;
        cyc(3);
    endtask

    task automatic mode_to(input logic [6:0] md, input logic sel, input logic pol);
        @(posedge clk);
        ctrl.mode              <= md;
        ctrl.edge_select_bit   <= sel;
        ctrl.edge_polarity_bit <= pol;
        cyc(3);
    endtask

    task automatic clr;
        @(posedge clk);
        fclr <= 1'b1;
        @(posedge clk);
        fclr <= 1'b0;
        cyc(2);
    endtask

    // time base held steady across the synchroniser delay
    task automatic edge_at(input logic l, input logic [15:0] v);
        @(posedge clk);
        bus_a <= v;
        bus_b <= ~v;
        pin_drv.drive(l);
        cyc(8);
    endtask

    task automatic pulse(input logic lf, input logic lock);
        logic [15:0] ld;
        logic [15:0] tr;
        ld = 16'($urandom);
        tr = 16'($urandom);
        edge_at(1'b1, ld);
        chk1("lead flag", lf, flag);
        edge_at(1'b0, tr);
        a1_v = ld;
        if (!lock) exp_b = ld;
        chk16("trail data a", tr, da);
        chk16("pulse data b", exp_b, db);
        chk1("trail flag", 1'b1, flag);
    endtask

    task automatic report_and_stop;
        if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // watchdog well past the expected run length
    initial begin
        #200000;
        errors++;
        report_and_stop();
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        clk = 1'b0; rst = 1'b1; fclr = 1'b0; ctrl = '0; host = '0; bus_a = '0; bus_b = '0;
        errors = 0; checks_done = 0;
        void'($urandom(24));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        bus_b <= 16'($urandom);
        cyc(1);
        chk16("reset data a", 16'h0000, da);
        chk16("reset data b", 16'h0000, db);
        chk1("reset flag", 1'b0, flag);
        chk1("reset pin out", 1'b0, pout);
        // pin input mode: level, flag, counter held
        mode_to(`UTC_MODE_PIN_IN, 1'b0, 1'b1);
        clr();
        pin_drv.drive(1'b1);
        cyc(6);
        chk1("pin level", 1'b1, lvl);
        chk1("pin flag", 1'b1, flag);
        chk16("pin mode count", 16'h0000, cnt);
        pin_drv.drive(1'b0);
        cyc(6);
        m = 16'($urandom);
        host_op(5'b10000, m);
        chk16("pin write a", m, da);
        host_op(5'b00100, ~m);
        chk16("alt write a2", ~m, da);
        host_op(5'b01000, ~m);
        chk16("pin write b", ~m, db);
        // output pin mode
        mode_to(`UTC_MODE_PIN_OUT, 1'b0, 1'b0);
        chk1("out pin low", 1'b0, pout);
        mode_to(`UTC_MODE_PIN_OUT, 1'b0, 1'b1);
        chk1("out pin high", 1'b1, pout);
        // single compare on bus a
        @(posedge clk);
        bus_a <= ~m;
        mode_to(`UTC_MODE_COMPARE, 1'b0, 1'b1);
        chk1("entry pin out", 1'b0, pout);
        chk16("compare read a1", m, da);
        @(posedge clk);
        bus_a <= m;
        @(posedge clk);
        bus_a <= ~m;
        cyc(3);
        chk1("match flag", 1'b1, flag);
        chk1("match load pol", 1'b1, pout);
        clr();
        mode_to(`UTC_MODE_COMPARE, 1'b1, 1'b1);
        @(posedge clk);
        ctrl.force_match_a_bit <= 1'b1;
        @(posedge clk);
        ctrl.force_match_a_bit <= 1'b0;
        cyc(3);
        chk1("force toggle", 1'b0, pout);
        chk1("force no flag", 1'b0, flag);
        c0 = cnt;
        cyc(10);
        chk16("free count", c0 + 16'h000A, cnt);
        // match on internal counter after a live update
        @(posedge clk);
        ctrl.bus_select_field <= `UTC_BSL_INTERNAL;
        cyc(1);
        m = cnt + 16'h0040;
        host_op(5'b10000, m);
        chk16("compare update a1", m, da);
        cyc(80);
        chk1("internal match flag", 1'b1, flag);
        chk1("internal toggle", 1'b1, pout);
        @(posedge clk);
        ctrl.bus_select_field <= `UTC_BSL_BUS_A;
        // single capture over every edge choice
        for (int k = 0; k < 3; k++) begin
            s = (k == 2);
            p = (k == 0);
            mode_to(`UTC_MODE_PIN_IN, s, p);
            @(posedge clk);
            ctrl.bus_select_field <= (k == 1) ? `UTC_BSL_BUS_B : `UTC_BSL_BUS_A;
            exp_a = 16'($urandom);
            host_op(5'b10000, exp_a);
            mode_to(`UTC_MODE_CAPTURE, s, p);
            clr();
            for (int e = 0; e < 2; e++) begin
                m = 16'($urandom);
                edge_at(e == 0, m);
                if (trig(s, p, e == 0)) exp_a = (k == 1) ? ~m : m;
                chk16("capture data", exp_a, da);
                chk1("capture flag", trig(s, p, e == 0), flag);
                clr();
            end
        end
        // pulse width with coherent reads
        mode_to(`UTC_MODE_PIN_IN, 1'b0, 1'b1);
        pin_drv.drive(1'b1);
        cyc(6);
        mode_to(`UTC_MODE_PULSE, 1'b0, 1'b1);
        clr();
        edge_at(1'b0, 16'($urandom));
        chk1("trail before lead", 1'b0, flag);
        pulse(1'b0, 1'b0);
        pulse(1'b1, 1'b0);
        host_op(5'b00010, 16'h0000);
        pulse(1'b1, 1'b1);
        host_op(5'b00010, 16'h0000);
        exp_b = a1_v;
        chk16("read a loads b1", exp_b, db);
        pulse(1'b1, 1'b1);
        host_op(5'b00001, 16'h0000);
        exp_b = a1_v;
        chk16("read b loads b1", exp_b, db);
        pulse(1'b1, 1'b0);
        report_and_stop();
    end
endmodule // unified_timer_channel_tb

// ### verification/utc_pin_model.sv
`timescale 1ns/10ps

// external signal source at the channel pin
module utc_pin_model (
    // clock
    input  wire logic clk_in,
    // pin
    output logic      pin_out
);
    // pin rests low until a scenario moves it
    initial pin_out = 1'b0;

    // change the level just after a rising edge, like any clocked source
    task automatic drive(input logic level);
        @(posedge clk_in);
        pin_out <= level;
    endtask
endmodule // utc_pin_model

// ### verilog/utc_channel.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`include "utc_map.svh"

module utc_channel #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic                 CLK_IN,
    input  wire logic                 RST_IN,
    // control
    input  wire utc_pkg::utc_ctrl_t   CTRL_IN,
    input  wire logic                 FLAG_CLEAR_IN,
    // host data access
    input  wire utc_pkg::utc_host_t   HOST_IN,
    // shared counter buses
    input  wire logic [WIDTH-1:0]     BUS_A_IN,
    input  wire logic [WIDTH-1:0]     BUS_B_IN,
    // pin
    input  wire logic                 PIN_IN,
    // status and data
    output logic [WIDTH-1:0]          DATA_A_OUT,
    output logic [WIDTH-1:0]          DATA_B_OUT,
    output logic [WIDTH-1:0]          COUNT_OUT,
    output logic                      FLAG_OUT,
    output logic                      PIN_LEVEL_OUT,
    output logic                      PIN_OUT
);
    //////////////////////////////////////////////////////////////////////////
    // declarations
    logic [WIDTH-1:0]        a1, a2, b1, b2;
    logic [WIDTH-1:0]        count, time_base;
    logic                    level, rise, fall;
    logic                    is_pin, was_active, trig, lead, trail, match;
    logic                    lock_b1;
    logic [WIDTH-1:0]        next_a2;
    utc_pkg::utc_pw_state_t  pw_state;
    logic [6:0]              mode;

    assign mode   = CTRL_IN.mode;
    assign is_pin = (mode == `UTC_MODE_PIN_IN) || (mode == `UTC_MODE_PIN_OUT);

    // edge trigger selection
    function automatic logic edge_hit(input logic sel, input logic pol,
                                      input logic r, input logic f);
        edge_hit = sel ? (r | f) : (pol ? r : f);
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // pin front end and internal counter
    utc_sync u_sync (
        .clk_in    (CLK_IN),
        .rst_in    (RST_IN),
        .pin_in    (PIN_IN),
        .level_out (level),
        .rise_out  (rise),
        .fall_out  (fall)
    );

    // counter held cleared in pin mode, free otherwise
    utc_counter #(.WIDTH(WIDTH)) u_cnt (
        .clk_in    (CLK_IN),
        .rst_in    (RST_IN),
        .hold_in   (is_pin),
        .count_out (count)
    );

    // time base selection
    always_comb begin
        unique case (CTRL_IN.bus_select_field)
            `UTC_BSL_BUS_A:    time_base = BUS_A_IN;
            `UTC_BSL_BUS_B:    time_base = BUS_B_IN;
            default:           time_base = count;
        endcase
    end

    // shared bus B feeds captures and matches when chosen
    a_bus_b_base: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        CTRL_IN.bus_select_field == `UTC_BSL_BUS_B |-> time_base == BUS_B_IN)
        else $error("bus B not used as time base");

    assign trig  = edge_hit(CTRL_IN.edge_select_bit, CTRL_IN.edge_polarity_bit, rise, fall);
    assign lead  = CTRL_IN.edge_polarity_bit ? rise : fall;
    assign trail = CTRL_IN.edge_polarity_bit ? fall : rise;
    assign match = (mode == `UTC_MODE_COMPARE) && (a1 == time_base);

    // remembers a cycle outside pin mode; cleared state reads as pin mode
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            was_active <= 1'b0;
        end else begin
            was_active <= !is_pin;
        end
    end

    // first compare cycle after a pin mode cycle
    sequence s_entry;
        mode == `UTC_MODE_COMPARE && !was_active;
    endsequence

    //////////////////////////////////////////////////////////////////////////
    // A2 register
    always_comb begin
        next_a2 = a2;
        if (HOST_IN.wr_a || HOST_IN.wr_alt_a) begin
            next_a2 = HOST_IN.wdata[WIDTH-1:0];
        end
        if (mode == `UTC_MODE_CAPTURE && trig) begin
            next_a2 = time_base;
        end
        if (mode == `UTC_MODE_PULSE && pw_state == utc_pkg::UTC_PW_WAIT_TRAIL && trail) begin
            next_a2 = time_base;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            a2 <= `UTC_DATA_RESET;
        end else begin
            a2 <= next_a2;
        end
    end

    // A1 register
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            a1 <= `UTC_DATA_RESET;
        end else if (is_pin && HOST_IN.wr_a) begin
            a1 <= HOST_IN.wdata[WIDTH-1:0];
        end else if (mode == `UTC_MODE_COMPARE && HOST_IN.wr_a) begin
            a1 <= HOST_IN.wdata[WIDTH-1:0];
        end else if (mode == `UTC_MODE_PULSE && pw_state == utc_pkg::UTC_PW_WAIT_TRAIL && trail) begin
            a1 <= b2;
        end
    end

    // compare mode write passes straight through to A1
    a_compare_write: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (mode == `UTC_MODE_COMPARE && HOST_IN.wr_a) |=> (a1 == $past(HOST_IN.wdata) && a2 == a1))
        else $error("compare write did not reach A1");

    // B2 register
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            b2 <= `UTC_DATA_RESET;
        end else if (HOST_IN.wr_b) begin
            b2 <= HOST_IN.wdata[WIDTH-1:0];
        end else if (mode == `UTC_MODE_PULSE && pw_state == utc_pkg::UTC_PW_WAIT_LEAD && lead) begin
            b2 <= time_base;
        end
    end

    // B1 register with coherent-read lock
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            b1 <= `UTC_DATA_RESET;
        end else if (is_pin && HOST_IN.wr_b) begin
            b1 <= HOST_IN.wdata[WIDTH-1:0];
        end else if (mode == `UTC_MODE_PULSE && (HOST_IN.rd_a || HOST_IN.rd_b)) begin
            b1 <= a1;
        end else if (mode == `UTC_MODE_PULSE && pw_state == utc_pkg::UTC_PW_WAIT_TRAIL && trail
                     && !lock_b1) begin
            b1 <= b2;
        end
    end

    // pin mode B write fills both B stages
    a_pin_write_b: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (is_pin && HOST_IN.wr_b) |=> (b1 == $past(HOST_IN.wdata) && b2 == b1))
        else $error("pin mode B write missed a stage");

    // lock set on A read, released on B read
    always_ff @(posedge CLK_IN) begin
        if (RST_IN || is_pin) begin
            lock_b1 <= 1'b0;
        end else if (mode == `UTC_MODE_PULSE && HOST_IN.rd_a) begin
            lock_b1 <= 1'b1;
        end else if (mode == `UTC_MODE_PULSE && HOST_IN.rd_b) begin
            lock_b1 <= 1'b0;
        end
    end

    // B read refreshes B1 from A1 and frees it
    a_read_b_unlock: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (mode == `UTC_MODE_PULSE && HOST_IN.rd_b && !HOST_IN.rd_a) |=> (!lock_b1 && b1 == $past(a1)))
        else $error("B read did not release B1");
    // locked B1 ignores trailing captures
    a_lock_holds: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (mode == `UTC_MODE_PULSE && pw_state == utc_pkg::UTC_PW_WAIT_TRAIL && trail && lock_b1
         && !HOST_IN.rd_a && !HOST_IN.rd_b) |=> b1 == $past(b1))
        else $error("locked B1 changed");

    // pulse width sequencing; A2 capture armed by first lead
    always_ff @(posedge CLK_IN) begin
        if (RST_IN || mode != `UTC_MODE_PULSE) begin
            pw_state <= utc_pkg::UTC_PW_WAIT_LEAD;
        end else begin
            unique case (pw_state)
                utc_pkg::UTC_PW_WAIT_LEAD: if (lead) begin
                    pw_state <= utc_pkg::UTC_PW_WAIT_TRAIL;
                end
                utc_pkg::UTC_PW_WAIT_TRAIL: if (trail) begin
                    pw_state <= utc_pkg::UTC_PW_WAIT_LEAD;
                end
            endcase
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // flag: set wins over clear
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            FLAG_OUT <= 1'b0;
        end else if ((mode == `UTC_MODE_PIN_IN && !CTRL_IN.edge_select_bit
                      && (CTRL_IN.edge_polarity_bit ? rise : fall))
                     || (mode == `UTC_MODE_CAPTURE && trig)
                     || match
                     || (mode == `UTC_MODE_PULSE && pw_state == utc_pkg::UTC_PW_WAIT_TRAIL
                         && trail)) begin
            FLAG_OUT <= 1'b1;
        end else if (FLAG_CLEAR_IN) begin
            FLAG_OUT <= 1'b0;
        end
    end

    // pin input flag on the chosen single edge
    a_pin_in_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (mode == `UTC_MODE_PIN_IN && !CTRL_IN.edge_select_bit && lead) |=> FLAG_OUT)
        else $error("pin input edge missed the flag");
    // flag stays set until cleared
    a_flag_sticky: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (FLAG_OUT && !FLAG_CLEAR_IN) |=> FLAG_OUT)
        else $error("flag dropped without clear");

    // output flip-flop
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            PIN_OUT <= 1'b0;
        end else if (mode == `UTC_MODE_PIN_OUT) begin
            PIN_OUT <= CTRL_IN.edge_polarity_bit;
        end else if (mode == `UTC_MODE_COMPARE && !was_active) begin
            PIN_OUT <= ~CTRL_IN.edge_polarity_bit;
        end else if (mode == `UTC_MODE_COMPARE && (match || CTRL_IN.force_match_a_bit)) begin
            PIN_OUT <= CTRL_IN.edge_select_bit ? ~PIN_OUT : CTRL_IN.edge_polarity_bit;
        end
    end

    // entry from pin mode drives the inverse level
    a_entry_level: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        s_entry |=> PIN_OUT == !$past(CTRL_IN.edge_polarity_bit))
        else $error("compare entry level wrong");
    // match outside entry: load polarity or toggle
    a_match_load: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (match && was_active && !CTRL_IN.edge_select_bit) |=> PIN_OUT == $past(CTRL_IN.edge_polarity_bit))
        else $error("match did not load polarity");
    a_match_toggle: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (match && was_active && CTRL_IN.edge_select_bit) |=> PIN_OUT != $past(PIN_OUT))
        else $error("match did not toggle");
    // forced match acts on the output like a real one
    a_force_toggle: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (mode == `UTC_MODE_COMPARE && was_active && CTRL_IN.force_match_a_bit && CTRL_IN.edge_select_bit)
        |=> PIN_OUT != $past(PIN_OUT))
        else $error("force did not toggle");

    // host read data and status
    always_ff @(posedge CLK_IN) begin
        if (RST_IN) begin
            DATA_A_OUT    <= `UTC_DATA_RESET;
            DATA_B_OUT    <= `UTC_DATA_RESET;
            COUNT_OUT     <= `UTC_DATA_RESET;
            PIN_LEVEL_OUT <= 1'b0;
        end else begin
            DATA_A_OUT    <= (mode == `UTC_MODE_COMPARE) ? a1 : a2;
            DATA_B_OUT    <= (mode == `UTC_MODE_PULSE) ? b1 : b2;
            COUNT_OUT     <= count;
            PIN_LEVEL_OUT <= level;
        end
    end

    // compare mode shows the active match value
    a_compare_read: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        mode == `UTC_MODE_COMPARE |=> DATA_A_OUT == $past(a1))
        else $error("compare read not from A1");

    //////////////////////////////////////////////////////////////////////////
    // assertions
    sequence s_lead;
        mode == `UTC_MODE_PULSE && pw_state == utc_pkg::UTC_PW_WAIT_LEAD && lead;
    endsequence
    sequence s_trail;
        mode == `UTC_MODE_PULSE && pw_state == utc_pkg::UTC_PW_WAIT_TRAIL && trail;
    endsequence

    a_reset_clears: assert property (@(posedge CLK_IN) RST_IN |=> (a1 == '0 && !FLAG_OUT && !PIN_OUT))
        else $error("reset did not clear state");
    a_pin_counter: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        is_pin |=> count == '0)
        else $error("counter not held in pin mode");
    a_counter_runs: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (!is_pin && !$past(is_pin)) |=> count == $past(count) + 1'b1)
        else $error("counter not running");
    a_pin_write_both: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (is_pin && HOST_IN.wr_a) |=> (a1 == a2))
        else $error("pin mode write missed a stage");
    a_alt_write_a2: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (HOST_IN.wr_alt_a && !HOST_IN.wr_a && !trig && mode != `UTC_MODE_PULSE)
        |=> (a2 == $past(HOST_IN.wdata) && a1 == $past(a1)))
        else $error("alternate write touched A1");
    a_gpo_follow: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        mode == `UTC_MODE_PIN_OUT |=> PIN_OUT == $past(CTRL_IN.edge_polarity_bit))
        else $error("output pin not following polarity");
    a_capture_a2: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (mode == `UTC_MODE_CAPTURE && trig) |=> (a2 == $past(time_base) && FLAG_OUT))
        else $error("capture failed");
    a_match_flag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        match |=> FLAG_OUT)
        else $error("match without flag");
    a_force_noflag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (mode == `UTC_MODE_COMPARE && CTRL_IN.force_match_a_bit && !match && !FLAG_OUT
         && was_active) |=> !FLAG_OUT)
        else $error("force set the flag");
    a_lead_noflag: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (s_lead and (!FLAG_OUT)) |=> (b2 == $past(time_base) && !FLAG_OUT))
        else $error("lead edge misbehaved");
    a_trail_xfer: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        s_trail |=> (a1 == $past(b2) && FLAG_OUT && a2 == $past(time_base)))
        else $error("trail transfer failed");
    a_read_lock: assert property (@(posedge CLK_IN) disable iff (RST_IN)
        (mode == `UTC_MODE_PULSE && HOST_IN.rd_a) |=> (lock_b1 && b1 == $past(a1)))
        else $error("A read did not lock B1");
endmodule // utc_channel

// ### verilog/utc_counter.sv
`timescale 1ns/10ps

// channel internal counter
module utc_counter #(
    parameter int WIDTH = 16
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             hold_in,
    output logic [WIDTH-1:0]      count_out
);
    // cleared and stopped while held, free running otherwise
    always_ff @(posedge clk_in) begin
        if (rst_in || hold_in) begin
            count_out <= '0;
        end else begin
            count_out <= count_out + 1'b1;
        end
    end
endmodule // utc_counter

// ### verilog/utc_sync.sv
`timescale 1ns/10ps

// three-stage pin synchroniser with edge detection
module utc_sync (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // pin
    input  wire logic pin_in,
    // filtered view
    output logic      level_out,
    output logic      rise_out,
    output logic      fall_out
);
    logic [2:0] stage;

    // shift chain; second and third agree before level follows
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            stage <= 3'h0;
        end else begin
            stage <= {stage[1:0], pin_in};
        end
    end

    // stable level and edges
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            level_out <= 1'b0;
            rise_out  <= 1'b0;
            fall_out  <= 1'b0;
        end else begin
            rise_out <= 1'b0;
            fall_out <= 1'b0;
            if (stage[1] == stage[2] && stage[2] != level_out) begin
                level_out <= stage[2];
                rise_out  <= stage[2];
                fall_out  <= ~stage[2];
            end
        end
    end
endmodule // utc_sync
